// ==== shared/i2cas_defs.svh ====
// Constants for the two-wire target address select block.
// Assumes inclusion by bare name from rtl and bench files.
`ifndef I2CAS_DEFS_SVH
`define I2CAS_DEFS_SVH
`define I2CAS_BASE_WR_ADDR 8'h70
`define I2CAS_GLOBAL_WR_ADDR 8'h80
`define I2CAS_STRAP_W 3
`define I2CAS_BYTE_BITS 4'h8
`define I2CAS_CKSUM_RESET 8'h00
`define I2CAS_BCAST_RESET 1'b1
`define I2CAS_ADDR_RESET 7'h38
`endif

// ==== shared/i2cas_pkg.sv ====
// Types for the two-wire target address select block.
// Assumes nothing beyond a SystemVerilog compiler.
package i2cas_pkg;
  // Receiver phases
  typedef enum logic [1:0] {
    I2CAS_IDLE,
    I2CAS_SHIFT,
    I2CAS_ACK,
    I2CAS_IGNORE
  } i2cas_state_t;
  // Received byte report
  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } i2cas_byte_t;
endpackage

// ==== rtl/i2cas_target.sv ====
// Two-wire target front end: address strap decode, broadcast match, write receive and checksum.
// Assumes bus pins are asynchronous to core_clk and sampled well above the bus bit rate.
`timescale 1ns/1ps
`include "i2cas_defs.svh"

// Overview of operation
// - Eight straps map to write addresses 0x70-0x7E
// - Latch strap address on shutdown pin release
// - Redetect request resamples strap, updates address
// - Broadcast enabled: also accept global address 0x80
// - Broadcast disabled: answer local address only
// - Checksum over received bytes is readable
// - Only configuration traffic uses two-wire bus
// - Hold data low through whole acknowledge period
// - Bytes shifted MSB first, eight bits, ack
module i2cas_target (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Device pins
  input wire logic shutdown_n_pin,
  input wire logic [`I2CAS_STRAP_W-1:0] addr_strap,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Control from the register map
  input wire logic broadcast_id_enable,
  input wire logic bus_id_redetect,
  input wire logic cksum_clear,
  // Status out
  output logic [6:0] bus_addr_q,
  output logic [7:0] command_checksum_reg,
  output i2cas_pkg::i2cas_byte_t rx_byte_q
);

  // Two-stage synchronisers for every pin
  logic [1:0] scl_s_q, sda_s_q, sdz_s_q;
  logic [`I2CAS_STRAP_W-1:0] strap_m_q, strap_s_q;
  logic scl_d1_q, sda_d1_q, sdz_d1_q, redet_d1_q;
  logic scl_rise, scl_fall, start_seen, stop_seen, sdz_release, redet_req;
  i2cas_pkg::i2cas_state_t state_q;
  logic [7:0] shreg_q;
  logic [3:0] bitcnt_q;
  logic addr_phase_q;
  logic sel_q;
  logic [7:0] byte_full;
  logic addr_hit;
  logic addr_hit_q; // Address verdict, held from the eighth rise to the eighth fall

  // Synchronise pins; only the second stage is read by logic
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      sdz_s_q <= 2'h0;
      strap_m_q <= '0;
      strap_s_q <= '0;
    end else if (clk_en) begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      sdz_s_q <= {sdz_s_q[0], shutdown_n_pin};
      strap_m_q <= addr_strap;
      strap_s_q <= strap_m_q;
    end
  end

  // Delayed copies for edge detection
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
      sdz_d1_q <= 1'b0;
      redet_d1_q <= 1'b0;
    end else if (clk_en) begin
      scl_d1_q <= scl_s_q[1];
      sda_d1_q <= sda_s_q[1];
      sdz_d1_q <= sdz_s_q[1];
      redet_d1_q <= bus_id_redetect;
    end
  end

  assign scl_rise = scl_s_q[1] & ~scl_d1_q;
  assign scl_fall = ~scl_s_q[1] & scl_d1_q;
  // Data edges while clock is high are start and stop
  assign start_seen = scl_s_q[1] & scl_d1_q & sda_d1_q & ~sda_s_q[1];
  assign stop_seen = scl_s_q[1] & scl_d1_q & ~sda_d1_q & sda_s_q[1];
  assign sdz_release = sdz_s_q[1] & ~sdz_d1_q;
  // Writing one is a request; edge so a held bit does not retrigger
  assign redet_req = bus_id_redetect & ~redet_d1_q;

  // Strap decode and latch; address 0x38 + strap gives 0x70..0x7E bytes
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      bus_addr_q <= `I2CAS_ADDR_RESET;
    end else if (clk_en && (sdz_release || redet_req)) begin
      // Seven-bit address is the write byte without its direction bit
      bus_addr_q <= 7'((`I2CAS_BASE_WR_ADDR >> 1) | 8'(strap_s_q));
    end
  end

  assign byte_full = {shreg_q[6:0], sda_s_q[1]};
  // Local match always; global match only while enabled
  assign addr_hit = (byte_full[7:1] == bus_addr_q)
    || (broadcast_id_enable && byte_full[7:1] == 7'(`I2CAS_GLOBAL_WR_ADDR >> 1));

  // Receiver: shifts on clock rise, answers acknowledge on clock fall
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= i2cas_pkg::I2CAS_IDLE;
      shreg_q <= 8'h00;
      bitcnt_q <= 4'h0;
      addr_phase_q <= 1'b0;
      sel_q <= 1'b0;
    end else if (clk_en) begin
      if (start_seen) begin
        state_q <= i2cas_pkg::I2CAS_SHIFT;
        bitcnt_q <= 4'h0;
        addr_phase_q <= 1'b1;
        sel_q <= 1'b0;
      end else if (stop_seen) begin
        state_q <= i2cas_pkg::I2CAS_IDLE;
      end else begin
        unique case (state_q)
          i2cas_pkg::I2CAS_IDLE: begin
            bitcnt_q <= 4'h0;
          end
          i2cas_pkg::I2CAS_SHIFT: begin
            if (scl_rise) begin
              shreg_q <= byte_full;
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (scl_fall && bitcnt_q == `I2CAS_BYTE_BITS) begin
              bitcnt_q <= 4'h0;
              // Read requests and misses are left alone; only writes are taken
              if (addr_phase_q) begin
                sel_q <= addr_hit_q;
                state_q <= addr_hit_q ? i2cas_pkg::I2CAS_ACK : i2cas_pkg::I2CAS_IGNORE;
              end else begin
                state_q <= i2cas_pkg::I2CAS_ACK;
              end
              addr_phase_q <= 1'b0;
            end
          end
          i2cas_pkg::I2CAS_ACK: begin
            // Leave after the acknowledge clock falls
            if (scl_fall) begin
              state_q <= i2cas_pkg::I2CAS_SHIFT;
            end
          end
          i2cas_pkg::I2CAS_IGNORE: begin
            bitcnt_q <= 4'h0;
          end
        endcase
      end
    end
  end

  // Address verdict captured on the eighth rise, write bit must be zero
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      addr_hit_q <= 1'b0;
    end else if (clk_en && scl_rise && state_q == i2cas_pkg::I2CAS_SHIFT && bitcnt_q == 4'h7) begin
      addr_hit_q <= addr_hit && !sda_s_q[1];
    end
  end

  // Drive data low for the whole acknowledge period, released otherwise
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sda_out <= 1'b1;
      sda_oe_n <= 1'b1;
    end else if (clk_en) begin
      sda_out <= 1'b0;
      sda_oe_n <= !(state_q == i2cas_pkg::I2CAS_ACK) || start_seen || stop_seen;
    end
  end

  // Report each accepted data byte; global and local writes look the same downstream
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rx_byte_q <= '0;
    end else if (clk_en) begin
      rx_byte_q.valid <= 1'b0;
      if (scl_fall && state_q == i2cas_pkg::I2CAS_SHIFT && bitcnt_q == `I2CAS_BYTE_BITS
          && !addr_phase_q && sel_q) begin
        rx_byte_q.valid <= 1'b1;
        rx_byte_q.data <= shreg_q;
        rx_byte_q.first <= 1'b0;
      end
    end
  end

  // Checksum over accepted data bytes; a clear in the cycle a byte lands restarts the sum from that byte
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      command_checksum_reg <= `I2CAS_CKSUM_RESET;
    end else if (clk_en) begin
      if (rx_byte_q.valid) begin
        command_checksum_reg <= (cksum_clear ? `I2CAS_CKSUM_RESET : command_checksum_reg)
          + rx_byte_q.data;
      end else if (cksum_clear) begin
        command_checksum_reg <= `I2CAS_CKSUM_RESET;
      end
    end
  end

  // Checks
  property p_ack_low;
    @(posedge core_clk) disable iff (!rstn)
    (clk_en && state_q == i2cas_pkg::I2CAS_ACK && !start_seen && !stop_seen) |=> (!sda_oe_n || !clk_en);
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack not driven");

  property p_latch;
    @(posedge core_clk) disable iff (!rstn)
    (clk_en && sdz_release) |=> bus_addr_q == ((`I2CAS_BASE_WR_ADDR >> 1) | 7'($past(strap_s_q)));
  endproperty
  a_latch: assert property (p_latch) else $error("address not latched");

  property p_redet;
    @(posedge core_clk) disable iff (!rstn)
    (clk_en && redet_req) |=> bus_addr_q[2:0] == $past(strap_s_q);
  endproperty
  a_redet: assert property (p_redet) else $error("redetect missed");

  property p_range;
    @(posedge core_clk) disable iff (!rstn)
    (!sdz_s_q[1]) ##1 sdz_s_q[1] ##2 1 |-> bus_addr_q[6:3] == 4'h7;
  endproperty
  a_range: assert property (p_range) else $error("address outside range");

  property p_no_bcast;
    @(posedge core_clk) disable iff (!rstn)
    (clk_en && !broadcast_id_enable && scl_rise && state_q == i2cas_pkg::I2CAS_SHIFT && bitcnt_q == 4'h7
      && byte_full[7:1] == 7'h40 && bus_addr_q != 7'h40) |=> !addr_hit_q;
  endproperty
  a_no_bcast: assert property (p_no_bcast) else $error("global answered while off");

  property p_bcast;
    @(posedge core_clk) disable iff (!rstn)
    (clk_en && broadcast_id_enable && scl_rise && state_q == i2cas_pkg::I2CAS_SHIFT && bitcnt_q == 4'h7
      && byte_full == 8'h80) |=> addr_hit_q;
  endproperty
  a_bcast: assert property (p_bcast) else $error("global not answered");

  property p_cksum;
    @(posedge core_clk) disable iff (!rstn)
    (clk_en && rx_byte_q.valid && !cksum_clear) |=> command_checksum_reg == 8'($past(command_checksum_reg)
      + $past(rx_byte_q.data));
  endproperty
  a_cksum: assert property (p_cksum) else $error("checksum wrong");

  property p_count;
    @(posedge core_clk) disable iff (!rstn)
    state_q == i2cas_pkg::I2CAS_SHIFT |-> bitcnt_q <= `I2CAS_BYTE_BITS;
  endproperty
  a_count: assert property (p_count) else $error("bit count overrun");

  property p_release;
    @(posedge core_clk) disable iff (!rstn)
    (clk_en && state_q == i2cas_pkg::I2CAS_IDLE) |=> (sda_oe_n || !clk_en);
  endproperty
  a_release: assert property (p_release) else $error("bus held while idle");
endmodule

// ==== bench/i2cas_host.sv ====
// Two-wire bus host model that drives clock and data for write frames.
// Assumes a pulled-up data wire resolved by the bench.
`timescale 1ns/1ps
module i2cas_host (
  // Clock
  input wire logic core_clk,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Phase length, well above the receiver's minimum
  localparam int T = 8;
  // Bus idles high on both lines
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One clock phase
  task automatic ph;
    repeat (T) @(negedge core_clk);
  endtask
  // Data falls while the clock is high
  task automatic start;
    sda_low = 1'b1;
    ph;
    scl = 1'b0;
    ph;
  endtask
  // Data rises while the clock is high
  task automatic stop;
    sda_low = 1'b1;
    ph;
    scl = 1'b1;
    ph;
    sda_low = 1'b0;
    ph;
  endtask
  // Eight bits then an acknowledge slot, sampled at both ends of its high phase
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = !b[i];
      ph;
      scl = 1'b1;
      ph;
      scl = 1'b0;
      ph;
    end
    sda_low = 1'b0;
    ph;
    scl = 1'b1;
    ack = !sda;
    ph;
    ack = ack & !sda;
    scl = 1'b0;
    ph;
  endtask
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the address select target.
// Assumes the host model drives the bus; one clock only.
`timescale 1ns/1ps
`include "i2cas_defs.svh"
module testbench;
  logic core_clk, rstn, clk_en, shutdown_n_pin, broadcast_id_enable, bus_id_redetect, cksum_clear;
  logic [2:0] addr_strap;
  logic scl, sda_low, sda_out, sda_oe_n, ka, kd;
  wire sda = (sda_low || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1; // Pull-up wins when released
  logic [6:0] bus_addr_q;
  logic [7:0] command_checksum_reg, last_rx, sum;
  i2cas_pkg::i2cas_byte_t rx_byte_q;
  int errors, n_compared, cyc;
  // Rows: expected address beside the data byte; strap is the row index
  logic [14:0] rows [8] = '{{7'h38, 8'h81}, {7'h39, 8'hc3}, {7'h3a, 8'h01}, {7'h3b, 8'h80},
    {7'h3c, 8'ha5}, {7'h3d, 8'h5a}, {7'h3e, 8'hfe}, {7'h3f, 8'h7f}};
  i2cas_target u_i2cas_target (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
    .shutdown_n_pin(shutdown_n_pin), .addr_strap(addr_strap), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .broadcast_id_enable(broadcast_id_enable),
    .bus_id_redetect(bus_id_redetect), .cksum_clear(cksum_clear), .bus_addr_q(bus_addr_q),
    .command_checksum_reg(command_checksum_reg), .rx_byte_q(rx_byte_q));
  i2cas_host u_i2cas_host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;
  // Keep the last byte reported, since the valid pulse lasts one cycle
  always @(posedge core_clk) begin
    if (rx_byte_q.valid === 1'b1) begin
      last_rx <= rx_byte_q.data;
    end
  end
  // Hang guard, far above the expected run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One write frame: address byte then one data byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_i2cas_host.start;
    u_i2cas_host.put(a, ka);
    u_i2cas_host.put(d, kd);
    u_i2cas_host.stop;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {rstn, shutdown_n_pin, addr_strap, bus_id_redetect, cksum_clear} = '0;
    {clk_en, broadcast_id_enable} = 2'b11;
    {errors, n_compared, cyc, sum, last_rx} = '0;
    wait_n(4);
    rstn = 1'b1;
    chk({1'b0, bus_addr_q}, {1'b0, `I2CAS_ADDR_RESET});
    chk(command_checksum_reg, `I2CAS_CKSUM_RESET);
    // Each strap: release shutdown, then a local write
    for (int i = 0; i < 8; i++) begin
      addr_strap = i[2:0];
      shutdown_n_pin = 1'b0;
      wait_n(4);
      shutdown_n_pin = 1'b1;
      wait_n(8);
      chk({1'b0, bus_addr_q}, {1'b0, rows[i][14:8]});
      wr({rows[i][14:8], 1'b0}, rows[i][7:0]);
      sum += rows[i][7:0];
      chk({6'h00, ka, kd}, 8'h03);
      chk(last_rx, rows[i][7:0]);
      chk(command_checksum_reg, sum);
    end
    // Read bit set is refused
    wr(8'h7f, 8'h11);
    chk({7'h00, ka}, 8'h00);
    chk(command_checksum_reg, sum);
    // Broadcast write lands like a local one; its acknowledge is not used
    wr(`I2CAS_GLOBAL_WR_ADDR, 8'h3c);
    sum += 8'h3c;
    chk(last_rx, 8'h3c);
    chk(command_checksum_reg, sum);
    // Broadcast off: global refused, local still answered
    broadcast_id_enable = 1'b0;
    wr(`I2CAS_GLOBAL_WR_ADDR, 8'h99);
    chk({7'h00, ka}, 8'h00);
    chk(command_checksum_reg, sum);
    wr(8'h7e, 8'h01);
    sum += 8'h01;
    chk({7'h00, ka}, 8'h01);
    chk(command_checksum_reg, sum);
    // Strap change alone does nothing; a redetect picks it up
    addr_strap = 3'h2;
    wait_n(8);
    chk({1'b0, bus_addr_q}, 8'h3f);
    bus_id_redetect = 1'b1;
    wait_n(8);
    bus_id_redetect = 1'b0;
    chk({1'b0, bus_addr_q}, 8'h3a);
    // Clear with no byte landing: the checksum returns to zero
    cksum_clear = 1'b1;
    wait_n(1);
    cksum_clear = 1'b0;
    wait_n(2);
    chk(command_checksum_reg, 8'h00);
    // Frozen clock enable: a redetect pulse and a strap change are not taken
    clk_en = 1'b0;
    addr_strap = 3'h5;
    bus_id_redetect = 1'b1;
    wait_n(8);
    bus_id_redetect = 1'b0;
    wait_n(2);
    chk({1'b0, bus_addr_q}, 8'h3a);
    clk_en = 1'b1;
    wait_n(8);
    chk({1'b0, bus_addr_q}, 8'h3a);
    rstn = 1'b0;
    wait_n(4);
    rstn = 1'b1;
    chk({1'b0, bus_addr_q}, {1'b0, `I2CAS_ADDR_RESET});
    // Shutdown pin already high: the strap is latched again after reset
    wait_n(8);
    chk({1'b0, bus_addr_q}, 8'h3d);
    finish_test;
  end
endmodule
